// ==== hdl/waveform_microsequencer.sv ====
// Function
// - eight accumulators; 0 ref, 1 var, 4 counter
// - cycle start loads files 3,2,1 into 0,1,4
// - each step adds increment file to accumulators
// - angle sums wrap modulo two full turns
// - counter sign bit feeds sequencer condition
// - converter uses middle 18 angle bits
// - 16-bit sine returned on upper bus lines
// - converter isolated from bus while converting
// - capture and drive commands steer converter
// - latched pair moves to DACs on strobe once armed by timing command
// - 256x16 program store, 8-bit address
// - bits 15:14 select instruction format
// - mode field picks next address source
// - stack field: off, pop, push
// - jump target in low eight bits
// - 0400 jumps to address register
// - run or step loads start address
// - 0Caa jumps unconditionally
// - 1Caa ORs condition bits into target
// - zero instruction steps to next address
// - 0AXX returns via stack top
// - datapath frozen in sequencer, bus cycles
`timescale 1ns/1ps
`include "waveform_microsequencer_defines.svh"

module waveform_microsequencer (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // host register port
   input wire logic [10:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // dac side
   input wire logic dac_strobe,
   output logic [15:0] dac_ref,
   output logic [15:0] dac_var,
   output logic dac_load
);

   // ***************************************************
   // declarations
   // ***************************************************
   logic [15:0] prog_mem [0:255];
   logic [31:0] rdata_q, rdata_d;
   waveform_microsequencer_pkg::angle_t file_q [1:3];
   waveform_microsequencer_pkg::angle_t file_d [1:3];
   logic [7:0] start_q, start_d;
   logic run_q, run_d, step_q, step_d;
   logic [7:0] pc_q, pc_d, ar_q, ar_d;
   logic [1:0] sp_q, sp_d;
   logic [7:0] stack_q [0:3];
   logic [7:0] stack_d [0:3];
   logic [15:0] exec_q, exec_d;
   waveform_microsequencer_pkg::seq_instr_s seq_ir;
   logic [15:0] fetch;
   logic [7:0] cond_word;
   logic core_en;
   waveform_microsequencer_pkg::angle_t acc_q [0:7];
   waveform_microsequencer_pkg::angle_t acc_d [0:7];
   waveform_microsequencer_pkg::angle_t file0_q, file0_d;
   waveform_microsequencer_pkg::angle_t alu_d, alu_res, bus_val;
   waveform_microsequencer_pkg::alu_instr_s xi;
   logic alu_cycle, ctl_cycle;
   waveform_microsequencer_pkg::conv_state_e conv_q, conv_d;
   logic [6:0] cnt_q, cnt_d;
   logic signed [17:0] x_q, x_d, y_q, y_d, z_q, z_d;
   logic neg_q, neg_d;
   logic [15:0] sine_q, sine_d;
   logic [17:0] ang;
   logic [17:0] atan_tab [0:15];
   waveform_microsequencer_pkg::dac_pair_s lat_q, lat_d, dac_q, dac_d;
   logic armed_q, armed_d, load_q, load_d;

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [7:0] word_index(input logic [10:0] a);
      word_index = a[9:2];
   endfunction : word_index

   function automatic logic is_ctl(input logic [15:0] ins);
      is_ctl = ins[15];
   endfunction : is_ctl

   genvar gi;
   generate
      for (gi = 0; gi < `CORDIC_STEPS; gi++)
      begin : g_atan
         localparam logic [18*`CORDIC_STEPS-1:0] TAB = `ATAN_TABLE;
         assign atan_tab[gi] = TAB[18*gi +: 18];
      end
   endgenerate

   // ***************************************************
   // host registers
   // ***************************************************
   always_comb
   begin
      file_d = file_q;
      start_d = start_q;
      run_d = run_q;
      step_d = 1'b0;
      rdata_d = 32'h0000_0000;
      if (wr && !addr[`PROG_SEL_BIT])
      begin
         case (addr)
            `OFF_FILE1: file_d[1] = wdata[19:0];
            `OFF_FILE2: file_d[2] = wdata[19:0];
            `OFF_FILE3: file_d[3] = wdata[19:0];
            `OFF_START: start_d = wdata[7:0];
            `OFF_CTRL:
            begin
               run_d = wdata[`CTRL_RUN];
               step_d = wdata[`CTRL_STEP] & ~wdata[`CTRL_RUN] & ~run_q;
            end
            default: ;
         endcase
      end
      if (rd)
      begin
         if (addr[`PROG_SEL_BIT])
            rdata_d[15:0] = prog_mem[word_index(addr)];
         else
         begin
            case (addr)
               `OFF_FILE1: rdata_d[19:0] = file_q[1];
               `OFF_FILE2: rdata_d[19:0] = file_q[2];
               `OFF_FILE3: rdata_d[19:0] = file_q[3];
               `OFF_START: rdata_d[7:0] = start_q;
               `OFF_CTRL: rdata_d[`CTRL_RUN] = run_q;
               `OFF_STATUS:
               begin
                  rdata_d[`STAT_RUN] = run_q;
                  rdata_d[`STAT_BUSY] = (conv_q == waveform_microsequencer_pkg::CONV_BUSY);
                  rdata_d[`STAT_WRAP] = acc_q[`ACC_COUNTER][19];
                  rdata_d[`STAT_ARMED] = armed_q;
                  rdata_d[`STAT_PC_LSB +: 8] = pc_q;
               end
               `OFF_ACC0: rdata_d[19:0] = acc_q[0];
               `OFF_ACC1: rdata_d[19:0] = acc_q[1];
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 1; i <= 3; i++)
            file_q[i] <= 20'h00000;
         start_q <= 8'h00;
         run_q <= 1'b0;
         step_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         file_q <= file_d;
         start_q <= start_d;
         run_q <= run_d;
         step_q <= step_d;
         rdata_q <= rdata_d;
      end
   end

   // program store, loaded by the host
   always_ff @(posedge clock)
   begin
      if (wr && addr[`PROG_SEL_BIT])
         prog_mem[word_index(addr)] <= wdata[15:0];
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   always_comb
   begin
      core_en = run_q | step_q;
      fetch = prog_mem[pc_q];
      seq_ir = (fetch[15:14] == `FMT_SEQ) ? fetch : 16'h0000;
      cond_word = 8'h00;
      cond_word[`COND_WRAP] = acc_d[`ACC_COUNTER][19];
      cond_word[`COND_BUSY] = (conv_q == waveform_microsequencer_pkg::CONV_BUSY);
      cond_word[`COND_ARMED] = armed_q;
      pc_d = pc_q;
      ar_d = ar_q;
      sp_d = sp_q;
      stack_d = stack_q;
      exec_d = 16'h0000;
      if ((wr && !addr[`PROG_SEL_BIT] && addr == `OFF_CTRL) && !run_q
         && (wdata[`CTRL_RUN] || wdata[`CTRL_STEP]))
         ar_d = start_q;
      if (core_en)
      begin
         exec_d = is_ctl(fetch) ? fetch : 16'h0000;
         case (seq_ir.stack)
            `STK_POP: sp_d = sp_q - 2'd1;
            `STK_PUSH:
            begin
               sp_d = sp_q + 2'd1;
               stack_d[sp_d] = pc_q + 8'd1;
            end
            default: ;
         endcase
         case (seq_ir.mode)
            `MODE_PC: pc_d = pc_q + 8'd1;
            `MODE_AR: pc_d = ar_q;
            `MODE_STACK: pc_d = stack_q[sp_q];
            `MODE_IR: pc_d = seq_ir.target | (seq_ir.cond_or ? cond_word : 8'h00);
            default: pc_d = pc_q + 8'd1;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         pc_q <= 8'h00;
         sp_q <= 2'd0;
         exec_q <= 16'h0000;
         ar_q <= 8'h00;
         for (int i = 0; i < 4; i++)
            stack_q[i] <= 8'h00;
      end
      else
      begin
         pc_q <= pc_d;
         sp_q <= sp_d;
         exec_q <= exec_d;
         ar_q <= ar_d;
         stack_q <= stack_d;
      end
   end

   // ***************************************************
   // arithmetic datapath
   // ***************************************************
   always_comb
   begin
      xi = exec_q;
      alu_cycle = (exec_q[15:14] == `FMT_ALU);
      ctl_cycle = is_ctl(exec_q);
      case (xi.src)
         `SRC_ALU_OUT: alu_d = file0_q;
         `SRC_INCR: alu_d = file_q[1];
         `SRC_VAR_INIT: alu_d = file_q[2];
         default: alu_d = file_q[3];
      endcase
      case (xi.fn)
         `FN_ADD: alu_res = acc_q[xi.dst] + alu_d;
         `FN_ADD1: alu_res = acc_q[xi.dst] + alu_d + 20'h00001;
         `FN_AND: alu_res = acc_q[xi.dst] & alu_d;
         `FN_LOAD: alu_res = alu_d;
         `FN_PASS: alu_res = acc_q[xi.dst];
         `FN_OR: alu_res = acc_q[xi.dst] | alu_d;
         `FN_XOR: alu_res = acc_q[xi.dst] ^ alu_d;
         default: alu_res = 20'h00000 - alu_d;
      endcase
      acc_d = acc_q;
      file0_d = file0_q;
      if (alu_cycle)
      begin
         acc_d[xi.dst] = alu_res;
         file0_d = alu_res;
      end
      bus_val = 20'h00000;
      if (alu_cycle && !xi.out_inh)
         bus_val = alu_res;
      else if (ctl_cycle && xi.bus_ctl == `BUS_DRIVE && conv_q == waveform_microsequencer_pkg::CONV_IDLE)
         bus_val = {sine_q, 4'h0};
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < 8; i++)
            acc_q[i] <= 20'h00000;
         file0_q <= 20'h00000;
      end
      else
      begin
         acc_q <= acc_d;
         file0_q <= file0_d;
      end
   end

   // ***************************************************
   // angle to sine converter
   // ***************************************************
   always_comb
   begin
      conv_d = conv_q;
      cnt_d = cnt_q;
      x_d = x_q;
      y_d = y_q;
      z_d = z_q;
      neg_d = neg_q;
      sine_d = sine_q;
      ang = bus_val[18:1] + (xi.trig_sel ? 18'h00000 : `QUARTER_TURN);
      case (conv_q)
         waveform_microsequencer_pkg::CONV_IDLE:
         begin
            if (ctl_cycle && xi.bus_ctl == `BUS_CAPTURE)
            begin
               conv_d = waveform_microsequencer_pkg::CONV_BUSY;
               cnt_d = 7'd0;
               neg_d = ang[17] ^ ang[16];
               z_d = {ang[17] ^ neg_d, ang[16:0]};
               x_d = `CORDIC_GAIN;
               y_d = 18'sh00000;
            end
         end
         waveform_microsequencer_pkg::CONV_BUSY:
         begin
            cnt_d = cnt_q + 7'd1;
            if (cnt_q < 7'(`CORDIC_STEPS))
            begin
               if (!z_q[17])
               begin
                  x_d = x_q - (y_q >>> cnt_q);
                  y_d = y_q + (x_q >>> cnt_q);
                  z_d = z_q - $signed(atan_tab[cnt_q[3:0]]);
               end
               else
               begin
                  x_d = x_q + (y_q >>> cnt_q);
                  y_d = y_q - (x_q >>> cnt_q);
                  z_d = z_q + $signed(atan_tab[cnt_q[3:0]]);
               end
            end
            if (cnt_q == 7'(`CONV_CYCLES - 1))
            begin
               conv_d = waveform_microsequencer_pkg::CONV_IDLE;
               sine_d = neg_q ? 16'(-y_q) : y_q[15:0];
            end
         end
         default: conv_d = waveform_microsequencer_pkg::CONV_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         conv_q <= waveform_microsequencer_pkg::CONV_IDLE;
         cnt_q <= 7'd0;
         x_q <= 18'sh00000;
         y_q <= 18'sh00000;
         z_q <= 18'sh00000;
         neg_q <= 1'b0;
         sine_q <= 16'h0000;
      end
      else
      begin
         conv_q <= conv_d;
         cnt_q <= cnt_d;
         x_q <= x_d;
         y_q <= y_d;
         z_q <= z_d;
         neg_q <= neg_d;
         sine_q <= sine_d;
      end
   end

   // ***************************************************
   // holding latches and dac transfer
   // ***************************************************
   always_comb
   begin
      lat_d = lat_q;
      dac_d = dac_q;
      load_d = 1'b0;
      if (ctl_cycle && xi.ref_le)
         lat_d.ref_val = bus_val[19:4];
      if (ctl_cycle && xi.var_le)
         lat_d.var_val = bus_val[19:4];
      armed_d = armed_q & ~dac_strobe;
      if (dac_strobe && armed_q)
      begin
         dac_d = lat_q;
         load_d = 1'b1;
      end
      if (ctl_cycle && xi.bus_ctl == `BUS_TIMING)
         armed_d = 1'b1;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lat_q <= '0;
         dac_q <= '0;
         armed_q <= 1'b0;
         load_q <= 1'b0;
      end
      else
      begin
         lat_q <= lat_d;
         dac_q <= dac_d;
         armed_q <= armed_d;
         load_q <= load_d;
      end
   end

   assign rdata = rdata_q;
   assign dac_ref = dac_q.ref_val;
   assign dac_var = dac_q.var_val;
   assign dac_load = load_q;

endmodule : waveform_microsequencer

// ==== hdl/waveform_microsequencer_defines.svh ====
`ifndef WAVEFORM_MICROSEQUENCER_DEFINES_SVH
`define WAVEFORM_MICROSEQUENCER_DEFINES_SVH

// ***************************************************
// host register byte offsets
// ***************************************************
`define OFF_FILE1 11'h000
`define OFF_FILE2 11'h004
`define OFF_FILE3 11'h008
`define OFF_START 11'h00c
`define OFF_CTRL 11'h010
`define OFF_STATUS 11'h014
`define OFF_ACC0 11'h018
`define OFF_ACC1 11'h01c
`define PROG_SEL_BIT 10
`define CTRL_RUN 0
`define CTRL_STEP 1
`define STAT_RUN 0
`define STAT_BUSY 1
`define STAT_WRAP 2
`define STAT_ARMED 3
`define STAT_PC_LSB 8

// ***************************************************
// instruction encodings
// ***************************************************
`define FMT_SEQ 2'b00
`define FMT_ALU 2'b10
`define FMT_BUS 2'b11
`define MODE_PC 2'b00
`define MODE_AR 2'b01
`define MODE_STACK 2'b10
`define MODE_IR 2'b11
`define STK_POP 2'b10
`define STK_PUSH 2'b11
`define BUS_CAPTURE 2'b01
`define BUS_DRIVE 2'b10
`define BUS_TIMING 2'b11
`define FN_ADD 3'h0
`define FN_ADD1 3'h1
`define FN_AND 3'h2
`define FN_LOAD 3'h3
`define FN_PASS 3'h4
`define FN_OR 3'h5
`define FN_XOR 3'h6
`define FN_NEG 3'h7
`define SRC_ALU_OUT 2'h0
`define SRC_INCR 2'h1
`define SRC_VAR_INIT 2'h2
`define SRC_REF_INIT 2'h3
`define ACC_COUNTER 3'h4
`define COND_WRAP 0
`define COND_BUSY 1
`define COND_ARMED 2

// ***************************************************
// timing and converter constants
// ***************************************************
`define CLK_NS 5
`define CONV_NS 300
`define CONV_CYCLES ((`CONV_NS + `CLK_NS - 1) / `CLK_NS)
`define CORDIC_STEPS 16
`define CORDIC_GAIN 18'h04db0
`define QUARTER_TURN 18'h10000
`define ATAN_TABLE {18'h00001, 18'h00003, 18'h00005, 18'h0000a, 18'h00014, 18'h00029, 18'h00051, 18'h000a3, \
   18'h00146, 18'h0028c, 18'h00517, 18'h00a2c, 18'h01444, 18'h027ed, 18'h04b90, 18'h08000}

`endif

// ==== hdl/waveform_microsequencer_pkg.sv ====
package waveform_microsequencer_pkg;

   // ***************************************************
   // instruction layouts
   // ***************************************************
   typedef struct packed {
      logic [1:0] fmt;
      logic spare;
      logic cond_or;
      logic [1:0] mode;
      logic [1:0] stack;
      logic [7:0] target;
   } seq_instr_s;

   typedef struct packed {
      logic [1:0] fmt;
      logic trig_sel;
      logic [1:0] bus_ctl;
      logic var_le;
      logic ref_le;
      logic out_inh;
      logic [1:0] src;
      logic [2:0] dst;
      logic [2:0] fn;
   } alu_instr_s;

   typedef struct packed {
      logic [15:0] ref_val;
      logic [15:0] var_val;
   } dac_pair_s;

   typedef enum logic [0:0] {
      CONV_IDLE,
      CONV_BUSY
   } conv_state_e;

   typedef logic [19:0] angle_t;

endpackage : waveform_microsequencer_pkg

// ==== tb/dac_side_model.sv ====
`timescale 1ns/1ps

module dac_side_model #(
   parameter int PERIOD = 37
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // dac bus
   input wire logic dac_load,
   input wire logic [15:0] dac_ref,
   input wire logic [15:0] dac_var,
   output logic dac_strobe,
   // observation
   output logic [31:0] loads,
   output waveform_microsequencer_pkg::dac_pair_s held
);
   int cnt;

   // ***************************************************
   // strobe source and converter capture
   // ***************************************************
   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         cnt <= 0;
         dac_strobe <= 1'b0;
         loads <= '0;
         held <= '0;
      end
      else
      begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         dac_strobe <= (cnt == PERIOD - 1);
         if (dac_load)
         begin
            held <= '{dac_ref, dac_var};
            loads <= loads + 32'h1;
         end
      end
endmodule : dac_side_model

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "waveform_microsequencer_defines.svh"

module testbench;
   logic clock = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dac_strobe, dac_load;
   logic [10:0] addr = '0;
   logic [31:0] wdata = '0, rdata, v, loads, n0, seed = 32'h29f5d454;
   logic [15:0] dac_ref, dac_var;
   waveform_microsequencer_pkg::dac_pair_s held;
   int error_cnt = 0, n_tests = 0, cyc = 0, refv, varv, expv, diff;
   logic [23:0] prog [16] = '{24'h0081c3, 24'h01818b, 24'h028140, 24'h038160, 24'h040400, 24'h100f30,
      24'h11a804, 24'h121c20, 24'h20f300, 24'h21d900, 24'h220c12, 24'h240c12, 24'h260c12, 24'h308140,
      24'h318160, 24'h320a00};

   always #2.5 clock = ~clock;

   waveform_microsequencer uut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .dac_strobe(dac_strobe), .dac_ref(dac_ref), .dac_var(dac_var), .dac_load(dac_load));
   dac_side_model #(.PERIOD(37)) far (.clock(clock), .rst(rst), .dac_load(dac_load), .dac_ref(dac_ref),
      .dac_var(dac_var), .dac_strobe(dac_strobe), .loads(loads), .held(held));

   // ***************************************************
   // helpers
   // ***************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr

   task report_and_stop();
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : report_and_stop

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h got %h", n, e, g);
      end
   endtask : chk

   task wr_reg(input logic [10:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_reg(input logic [10:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         report_and_stop();
      end
   end

   // ***************************************************
   // main sequence
   // ***************************************************
   initial
   begin
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      addr <= `OFF_STATUS;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 chk("status after reset", 32'h0, rdata);
      for (int i = 0; i < 16; i++)
         wr_reg({1'b1, prog[i][23:16], 2'b00}, {16'h0, prog[i][15:0]});
      seed = lfsr(seed);
      wr_reg(11'h7fc, seed);
      rd_reg(11'h7fc, v);
      chk("program word", {16'h0, seed[15:0]}, v);
      rd_reg(11'h020, v);
      chk("unmapped", 32'h0, v);
      seed = lfsr(seed);
      refv = {12'h0, 4'hf, seed[15:0]};
      varv = {12'h0, seed[31:12]};
      wr_reg(`OFF_FILE1, 32'h80000);
      wr_reg(`OFF_FILE2, varv);
      wr_reg(`OFF_FILE3, refv);
      wr_reg(`OFF_START, 32'h4);
      wr_reg(`OFF_CTRL, 32'h1);
      repeat (20) @(posedge clock);
      wr_reg(`OFF_CTRL, 32'h0);
      rd_reg(`OFF_ACC0, v);
      chk("acc0 wrap", (refv + 32'h80000) & 32'hfffff, v);
      rd_reg(`OFF_ACC1, v);
      chk("acc1", varv, v);
      rd_reg(`OFF_STATUS, v);
      chk("status stopped", 32'h0000_0404, v);
      wr_reg(`OFF_START, 32'h10);
      wr_reg(`OFF_CTRL, 32'h2);
      rd_reg(`OFF_STATUS, v);
      chk("status after step", 32'h0000_1004, v);
      wr_reg(`OFF_CTRL, 32'h1);
      repeat (200) @(posedge clock);
      rd_reg(`OFF_ACC0, v);
      chk("acc0 after call", refv, v);
      rd_reg(`OFF_CTRL, v);
      chk("run flag", 32'h1, v);
      n0 = loads;
      for (int i = 0; i < 100 && loads == n0; i++)
         @(posedge clock);
      #1 chk("dac load", 32'h1, {31'h0, loads != n0});
      chk("dac var", 32'h0, {16'h0, held.var_val});
      expv = $rtoi(32751.0 * $sin(6.283185307 * ((refv >> 1) & 32'h3ffff) / 262144.0));
      diff = $signed(held.ref_val) - expv;
      n_tests++;
      if (diff > 24 || diff < -24)
      begin
         error_cnt++;
         $display("CHECK FAILED dac ref expected %0d got %0d", expv, $signed(held.ref_val));
      end
      report_and_stop();
   end
endmodule : testbench

bind waveform_microsequencer ws_checker chk_i (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
   .rd(rd), .rdata(rdata), .dac_strobe(dac_strobe), .dac_ref(dac_ref), .dac_var(dac_var), .dac_load(dac_load));

// ==== tb/waveform_microsequencer_sva.sv ====
`timescale 1ns/1ps
`include "waveform_microsequencer_defines.svh"

module ws_checker (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // host port
   input wire logic [10:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [31:0] rdata,
   // dac side
   input wire logic dac_strobe,
   input wire logic [15:0] dac_ref,
   input wire logic [15:0] dac_var,
   input wire logic dac_load
);
   logic run_q, run_d, fresh_q, fresh_d;
   logic [15:0] mem_q [256];
   logic [255:0] mval_q;
   logic [31:0] echo_w;

   always_comb
   begin
      echo_w = {16'h0, mem_q[addr[9:2]]};
      run_d = (wr && addr == `OFF_CTRL) ? wdata[0] : run_q;
      fresh_d = fresh_q && !wr && !rd;
   end

   always_ff @(posedge clock or posedge rst)
      if (rst)
      begin
         run_q <= 1'b0;
         fresh_q <= 1'b1;
      end
      else
      begin
         run_q <= run_d;
         fresh_q <= fresh_d;
      end

   // program store mirror, not reset like the store
   always_ff @(posedge clock)
      if (wr && addr[10])
         mem_q[addr[9:2]] <= wdata[15:0];

   always_ff @(posedge clock or posedge rst)
      if (rst)
         mval_q <= '0;
      else if (wr && addr[10])
         mval_q[addr[9:2]] <= 1'b1;

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // ***************************************************
   // assertions
   // ***************************************************
   rdata_idle_a: assert property (!rd |=> rdata == 32'h0)
      else $error("rdata not zero outside read");
   prog_echo_a: assert property (rd && addr[10] && mval_q[addr[9:2]] |=> rdata == $past(echo_w))
      else $error("program word readback wrong");
   unmapped_read_a: assert property (rd && addr == 11'h020 |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   angle_width_a: assert property (rd && (addr == `OFF_ACC0 || addr == `OFF_ACC1) |=> rdata[31:20] == 12'h0)
      else $error("angle wider than 20 bits");
   reset_pc_a: assert property (rd && addr == `OFF_STATUS && fresh_q |=> rdata[15:8] == 8'h00)
      else $error("pc not zero after reset");
   run_flag_a: assert property (rd && addr == `OFF_CTRL |=> rdata[0] == $past(run_q))
      else $error("run flag wrong");
   load_cause_a: assert property (dac_load |-> $past(dac_strobe))
      else $error("dac load without strobe");
   dac_hold_a: assert property (!dac_load |-> $stable(dac_ref) && $stable(dac_var))
      else $error("dac words moved without load");

   cover property (dac_load);
   cover property (rd && addr[10]);
   cover property (wr && addr == `OFF_CTRL && wdata[0]);
endmodule : ws_checker
